/* File: design/sc_rx.sv */
// Behaviour
// [RL1] Card reception follows the normal asynchronous receive sequence.
// [RL2] A failed parity check sets the parity error flag.
// [RL3] Parity error flag with interrupt enable raises the error interrupt.
// [RL4] Software clears the parity error flag before the next parity bit.
// [RL5] A character with bad parity leaves the data-full flag clear.
// [RL6] Good parity keeps the error flag clear and sets data-full.
// [RL7] Data-full with interrupt enable raises the receive-complete interrupt.
// [RL8] Overrun or parity error raises the error interrupt; software clears it.
// [RL9] A character with bad parity is still moved into the data register.
// [RL10] Bad parity pulls the line low in the guard time for retransmission.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`include "sc_rx_consts.svh"

module sc_rx (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic card_data_i,
  output logic card_data_o,
  output logic card_data_oe_n_o,
  output sc_rx_pkg::rx_flags_t status_flags_o,
  output logic rx_complete_irq_o,
  output logic rx_error_irq_o,
  output logic irq_o
);

  import sc_rx_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  rx_state_t state_r;
  rx_ctrl_t serial_control_reg_r;
  rx_flags_t serial_status_reg_r;
  rx_flags_t status_nxt;
  rx_flags_t irq_mask_r;
  rx_flags_t set_flags;
  rx_flags_t clr_flags;
  logic [15:0] div_r;
  logic [7:0] rx_data_reg_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] err_cnt_r;
  logic parity_bad_r;
  logic line_prev_r;
  logic wait_r;
  logic [31:0] readdata_r;
  logic [31:0] rd_nxt;
  logic oe_n_r;
  logic data_out_r;
  logic rx_complete_irq_r;
  logic rx_error_irq_r;
  logic irq_r;
  logic wr_commit;
  logic start_edge;
  logic mid_tick;
  logic shift_sample;
  logic [7:0] shift_data;
  logic shift_parity;
  logic char_done;
  logic parity_fail;

  // ****************************************
  // Bit timing and data shifter
  // ****************************************
  assign start_edge = (state_r == ST_IDLE) && serial_control_reg_r.rx_enable &&
                      line_prev_r && !card_data_i;
  assign shift_sample = (state_r == ST_DATA) && mid_tick;

  etu_timer u_etu_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .restart_i(start_edge),
    .div_i(div_r),
    .mid_o(mid_tick)
  );

  rx_shifter u_rx_shifter (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(start_edge),
    .sample_i(shift_sample),
    .bit_i(card_data_i),
    .data_o(shift_data),
    .parity_o(shift_parity)
  );

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      line_prev_r <= 1'b1;
    end
    else
    begin
      line_prev_r <= card_data_i;
    end
  end

  // ****************************************
  // Character reception sequence
  // ****************************************
  assign char_done = (state_r == ST_PARITY) && mid_tick;
  assign parity_fail = (shift_parity ^ card_data_i) != serial_control_reg_r.odd_parity;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      err_cnt_r <= 2'h0;
      parity_bad_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (start_edge)
          begin
            state_r <= ST_START; // see [RL1]
          end
        ST_START:
          if (mid_tick)
          begin
            bit_cnt_r <= 3'h0;
            state_r <= card_data_i ? ST_IDLE : ST_DATA;
          end
        ST_DATA:
          if (mid_tick)
          begin
            if (bit_cnt_r == `LAST_DATA_BIT)
            begin
              state_r <= ST_PARITY;
            end
            else
            begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
          end
        ST_PARITY:
          if (mid_tick)
          begin
            parity_bad_r <= parity_fail;
            state_r <= ST_GUARD;
          end
        ST_GUARD:
          if (mid_tick)
          begin
            err_cnt_r <= 2'h0;
            state_r <= parity_bad_r ? ST_ERR_SIG : ST_IDLE; // see [RL10]
          end
        ST_ERR_SIG:
          if (mid_tick)
          begin
            if (err_cnt_r == `ERR_SIG_ETU - 2'h1)
            begin
              state_r <= ST_IDLE;
            end
            else
            begin
              err_cnt_r <= err_cnt_r + 2'h1;
            end
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Error signal on the card line
  // ****************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      oe_n_r <= 1'b1;
      data_out_r <= 1'b1;
    end
    else if ((state_r == ST_GUARD) && mid_tick && parity_bad_r)
    begin
      oe_n_r <= 1'b0; // see [RL10]
      data_out_r <= 1'b0;
    end
    else if ((state_r == ST_ERR_SIG) && mid_tick && (err_cnt_r == `ERR_SIG_ETU - 2'h1))
    begin
      oe_n_r <= 1'b1;
      data_out_r <= 1'b1;
    end
  end

  // ****************************************
  // Receive data register
  // ****************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_data_reg_r <= 8'h00;
    end
    else if (char_done && !serial_status_reg_r.rx_data_full_flag)
    begin
      rx_data_reg_r <= shift_data; // see [RL9]
    end
  end

  // ****************************************
  // Status flags, set wins over clear
  // ****************************************
  always_comb
  begin
    set_flags.parity_error_flag = char_done && parity_fail; // see [RL2]
    set_flags.rx_data_full_flag = char_done && !parity_fail &&
                                  !serial_status_reg_r.rx_data_full_flag; // see [RL5] [RL6]
    set_flags.overrun_error_flag = char_done && serial_status_reg_r.rx_data_full_flag;
    clr_flags = '0;
    if (wr_commit && (avs_address_i == `OFS_STATUS) && avs_byteenable_i[0])
    begin
      clr_flags = rx_flags_t'(avs_writedata_i[2:0]); // see [RL4] [RL8]
    end
    status_nxt = set_flags | (serial_status_reg_r & ~clr_flags);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      serial_status_reg_r <= '0;
    end
    else
    begin
      serial_status_reg_r <= status_nxt;
    end
  end

  // ****************************************
  // Interrupt requests
  // ****************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_complete_irq_r <= 1'b0;
      rx_error_irq_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      rx_complete_irq_r <= serial_control_reg_r.rx_interrupt_enable &&
                           serial_status_reg_r.rx_data_full_flag; // see [RL7]
      rx_error_irq_r <= serial_control_reg_r.rx_interrupt_enable &&
                        (serial_status_reg_r.parity_error_flag ||
                         serial_status_reg_r.overrun_error_flag); // see [RL3] [RL8]
      irq_r <= |(serial_status_reg_r & irq_mask_r);
    end
  end

  // ****************************************
  // Avalon-MM slave handshake
  // ****************************************
  assign wr_commit = avs_write_i && !wait_r;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wait_r <= 1'b1;
    end
    else if ((avs_read_i || avs_write_i) && wait_r)
    begin
      wait_r <= 1'b0;
    end
    else
    begin
      wait_r <= 1'b1;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      serial_control_reg_r <= '0;
      irq_mask_r <= '0;
      div_r <= `DIV_RESET;
    end
    else if (wr_commit)
    begin
      if ((avs_address_i == `OFS_CTRL) && avs_byteenable_i[0])
      begin
        serial_control_reg_r <= rx_ctrl_t'(avs_writedata_i[2:0]);
      end
      else if ((avs_address_i == `OFS_MASK) && avs_byteenable_i[0])
      begin
        irq_mask_r <= rx_flags_t'(avs_writedata_i[2:0]);
      end
      else if (avs_address_i == `OFS_DIV)
      begin
        if (avs_byteenable_i[0])
        begin
          div_r[7:0] <= avs_writedata_i[7:0];
        end
        if (avs_byteenable_i[1])
        begin
          div_r[15:8] <= avs_writedata_i[15:8];
        end
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_comb
  begin
    rd_nxt = `WORD_ZERO;
    if (avs_address_i == `OFS_CTRL)
      rd_nxt[2:0] = serial_control_reg_r;
    else if (avs_address_i == `OFS_STATUS)
    begin
      rd_nxt[2:0] = serial_status_reg_r;
      rd_nxt[`STAT_BUSY] = (state_r != ST_IDLE);
    end
    else if (avs_address_i == `OFS_DATA)
      rd_nxt[7:0] = rx_data_reg_r;
    else if (avs_address_i == `OFS_MASK)
      rd_nxt[2:0] = irq_mask_r;
    else if (avs_address_i == `OFS_DIV)
      rd_nxt[15:0] = div_r;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      readdata_r <= `WORD_ZERO;
    end
    else if (avs_read_i && wait_r)
    begin
      readdata_r <= rd_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata_o = readdata_r;
  assign avs_waitrequest_o = wait_r;
  assign card_data_o = data_out_r;
  assign card_data_oe_n_o = oe_n_r;
  assign status_flags_o = serial_status_reg_r;
  assign rx_complete_irq_o = rx_complete_irq_r;
  assign rx_error_irq_o = rx_error_irq_r;
  assign irq_o = irq_r;

endmodule // sc_rx

/* File: design/sc_rx_consts.svh */
`ifndef SC_RX_CONSTS_SVH
`define SC_RX_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 5'h00
`define OFS_STATUS 5'h04
`define OFS_DATA 5'h08
`define OFS_MASK 5'h0c
`define OFS_DIV 5'h10

// ****************************************
// Control and status field positions
// ****************************************
`define CTRL_RX_EN 0
`define CTRL_RIE 1
`define CTRL_ODD 2
`define STAT_BUSY 3

// ****************************************
// Reset values and timing counts
// ****************************************
`define DIV_RESET 16'h0174
`define DIV_MIN 16'h0002
`define LAST_DATA_BIT 3'h7
`define ERR_SIG_ETU 2'h1
`define WORD_ZERO 32'h0000_0000

`endif

/* File: design/sc_rx_pkg.sv */
package sc_rx_pkg;

  typedef struct packed {
    logic parity_error_flag;
    logic overrun_error_flag;
    logic rx_data_full_flag;
  } rx_flags_t;

  typedef struct packed {
    logic odd_parity;
    logic rx_interrupt_enable;
    logic rx_enable;
  } rx_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PARITY,
    ST_GUARD,
    ST_ERR_SIG
  } rx_state_t;

endpackage

/* File: design/etu_timer.sv */
`include "sc_rx_consts.svh"

module etu_timer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic [15:0] div_i,
  output logic mid_o
);

  logic [15:0] cnt_r;
  logic [15:0] div_eff;

  // ****************************************
  // Bit period counter, pulse at bit centre
  // ****************************************
  assign div_eff = (div_i < `DIV_MIN) ? `DIV_MIN : div_i;
  assign mid_o = (cnt_r == {1'b0, div_eff[15:1]}) && !restart_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || restart_i)
    begin
      cnt_r <= 16'h0000;
    end
    else if (cnt_r >= div_eff - 16'h0001)
    begin
      cnt_r <= 16'h0000;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

endmodule // etu_timer

/* File: design/rx_shifter.sv */
module rx_shifter (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic sample_i,
  input wire logic bit_i,
  output logic [7:0] data_o,
  output logic parity_o
);

  logic [7:0] shift_r;

  // ****************************************
  // LSB-first shift register
  // ****************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || clear_i)
    begin
      shift_r <= 8'h00;
    end
    else if (sample_i)
    begin
      shift_r <= {bit_i, shift_r[7:1]};
    end
  end

  assign data_o = shift_r;
  assign parity_o = ^shift_r;

endmodule // rx_shifter

/* File: testbench/sc_rx_asserts.sv */
module sc_rx_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic card_data_i,
  input wire logic card_data_o,
  input wire logic card_data_oe_n_o,
  input wire sc_rx_pkg::rx_flags_t status_flags_o,
  input wire logic rx_complete_irq_o,
  input wire logic rx_error_irq_o,
  input wire logic irq_o
);
  import sc_rx_pkg::*;

  // ****************************************
  // Port relations
  // ****************************************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_cplt_cause: assert property (rx_complete_irq_o |->
    $past(status_flags_o.rx_data_full_flag))
    else $error("complete irq without full flag");
  a_err_cause: assert property (rx_error_irq_o |->
    $past(status_flags_o.parity_error_flag | status_flags_o.overrun_error_flag))
    else $error("error irq without error flag");
  a_perr_nofull: assert property ($rose(status_flags_o.parity_error_flag) |->
    !$rose(status_flags_o.rx_data_full_flag))
    else $error("full flag set on parity error");
  a_perr_nocplt: assert property ($rose(status_flags_o.parity_error_flag) &&
    !status_flags_o.rx_data_full_flag |=> !rx_complete_irq_o)
    else $error("complete irq on parity error");
  a_sig_level: assert property (!card_data_oe_n_o |-> !card_data_o)
    else $error("error signal not low");
  a_sig_cause: assert property ($fell(card_data_oe_n_o) |->
    status_flags_o.parity_error_flag)
    else $error("error signal without parity error");
  a_sig_hold: assert property ($fell(card_data_oe_n_o) |-> !card_data_oe_n_o [*2])
    else $error("error signal too short");
  a_sig_release: assert property ($fell(card_data_oe_n_o) |->
    ##[1:1000] card_data_oe_n_o)
    else $error("error signal never released");
  a_irq_cause: assert property (irq_o |-> $past(status_flags_o != 3'h0))
    else $error("irq without status flag");
  a_bus_answer: assert property ($rose(avs_read_i) || $rose(avs_write_i) |=> !avs_waitrequest_o)
    else $error("bus not answered after one wait");

  cover property ($rose(status_flags_o.parity_error_flag));
  cover property ($rose(status_flags_o.overrun_error_flag));
  cover property ($fell(card_data_oe_n_o));
  cover property ($rose(rx_complete_irq_o));
endmodule // sc_rx_checker

bind sc_rx sc_rx_checker u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .card_data_i(card_data_i), .card_data_o(card_data_o), .card_data_oe_n_o(card_data_oe_n_o),
  .status_flags_o(status_flags_o), .rx_complete_irq_o(rx_complete_irq_o),
  .rx_error_irq_o(rx_error_irq_o), .irq_o(irq_o));

/* File: testbench/card_model.sv */
module card_model #(
  parameter int ETU = 8
) (
  input wire logic sys_clk_i,
  input wire logic line_i,
  output logic card_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Card sending one character
  // ****************************************
  logic err_seen;

  initial
  begin
    card_o = 1'b1;
    err_seen = 1'b0;
  end

  // Bad flips the parity bit on purpose
  task automatic send(input logic [7:0] d, input logic bad, input logic odd);
    logic [9:0] f;
    f = {(^d) ^ bad ^ odd, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk_i);
      card_o <= f[i];
      repeat (ETU - 1) @(posedge sys_clk_i);
    end
    @(posedge sys_clk_i);
    card_o <= 1'b1;
    repeat (ETU) @(posedge sys_clk_i);
    err_seen = !line_i;
    repeat (3 * ETU) @(posedge sys_clk_i);
  endtask
endmodule // card_model

/* File: testbench/tb_top.sv */
`include "sc_rx_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sc_rx_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wreq;
  logic cdo;
  logic oe_n;
  logic cpl;
  logic err;
  logic irq;
  logic card_o;
  rx_flags_t flg;
  wire logic line;
  int n_errors = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  // Open-drain line with pull-up
  assign line = card_o & (oe_n | cdo);

  sc_rx dut (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .card_data_i(line),
    .card_data_o(cdo), .card_data_oe_n_o(oe_n), .status_flags_o(flg),
    .rx_complete_irq_o(cpl), .rx_error_irq_o(err), .irq_o(irq));

  card_model #(.ETU(8)) card (.sys_clk_i(clk), .line_i(line), .card_o(card_o));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic results;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (wreq === 1'b0)
        break;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 20)
    begin
      n_errors++;
      $display("ERROR %0t bus timeout", $time);
      results();
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(`OFS_CTRL, 32'h0);
    rchk(`OFS_MASK, 32'h0);
    rchk(`OFS_DIV, {16'h0, `DIV_RESET});
    rchk(5'h14, 32'h0);
    acc(1'b1, `OFS_DIV, 32'h8);
    acc(1'b1, `OFS_MASK, 32'h7);
    acc(1'b1, `OFS_CTRL, 32'h3);
    card.send(8'ha5, 1'b0, 1'b0);
    rchk(`OFS_STATUS, 32'h1);
    chk(32'(flg), 32'h1);
    rchk(`OFS_DATA, 32'ha5);
    chk(32'(cpl), 32'h1);
    chk(32'(err), 32'h0);
    chk(32'(irq), 32'h1);
    chk(32'(card.err_seen), 32'h0);
    card.send(8'h5a, 1'b0, 1'b0);
    rchk(`OFS_STATUS, 32'h3);
    rchk(`OFS_DATA, 32'ha5);
    chk(32'(err), 32'h1);
    acc(1'b1, `OFS_STATUS, 32'h7);
    rchk(`OFS_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    card.send(8'h3c, 1'b1, 1'b0);
    rchk(`OFS_STATUS, 32'h4);
    chk(32'(flg), 32'h4);
    rchk(`OFS_DATA, 32'h3c);
    chk(32'(err), 32'h1);
    chk(32'(cpl), 32'h0);
    chk(32'(card.err_seen), 32'h1);
    acc(1'b1, `OFS_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    acc(1'b1, `OFS_STATUS, 32'h4);
    acc(1'b1, `OFS_CTRL, 32'h5);
    card.send(8'h3c, 1'b0, 1'b1);
    rchk(`OFS_STATUS, 32'h1);
    rchk(`OFS_DATA, 32'h3c);
    chk(32'(cpl), 32'h0);
    chk(32'(err), 32'h0);
    chk(32'(irq), 32'h1);
    results();
  end
endmodule // tb_top
